// ### verilog/gpap_pkg.sv
// gpap_pkg: constants shared by the port 0 general-purpose pin block.
// assumes a byte-wide register port and five usable pins at bits 2..6.
//
// Notes on behaviour
// (R01) output mode: data write loads latch; port mode drives latch on pin.
// (R02) output mode: data read returns the latch, not the pin.
// (R03) input mode: data write updates latch, pin state untouched.
// (R04) input mode: data read returns the sampled pin level.
// (R05) latch keeps its value until the next data write.
// (R06) data access ignores mode control; every bit reachable on its own.
// (R07) direction bit 0 means output, 1 means input.
// (R08) mode control 0 is plain port, 1 hands pin to alternate function.
// (R09) function select picks one of two alternates.
// (R10) extended select with function select picks among more alternates.
// (R11) drive select 0 push-pull, 1 n-channel open drain.
// (R12) drive select only counts in port mode with output direction.
// (R13) software sets selects before mode control, then edge selects.
// (R14) five pins at bits 2..6, each individually input or output.
// (R15) direction resets to all ones; bits 7, 1, 0 read one.
// (R16) alternates: nmi, irq0 or adc trigger, irq1..3, debug reset on 5.
// (R17) system holds debug reset pin low until debug enable cleared.
// (R18) debug enable set makes bit 5 the debug reset regardless of mode.
// (R19) bit 3 select 0 gives irq0, 1 gives adc trigger.
// (R20) mode control, selects and drive type reset to zero.
package gpap_pkg;
    localparam int GPAP_AW = 32;
    localparam int GPAP_DW = 8;
    localparam int GPAP_PIN_LO = 2;
    localparam int GPAP_PIN_N = 5;
    // register byte addresses
    localparam logic [31:0] GPAP_ADDR_DATA = 32'hfffff400;
    localparam logic [31:0] GPAP_ADDR_DIR = 32'hfffff420;
    localparam logic [31:0] GPAP_ADDR_MODE = 32'hfffff440;
    localparam logic [31:0] GPAP_ADDR_FSEL = 32'hfffff460;
    localparam logic [31:0] GPAP_ADDR_FSELE = 32'hfffff700;
    localparam logic [31:0] GPAP_ADDR_DRIVE = 32'hfffffc60;
    localparam logic [31:0] GPAP_ADDR_DEBUG = 32'hfffff9fc;
    // field layout and reset values
    localparam logic [7:0] GPAP_PIN_MASK = 8'h7c;
    localparam logic [7:0] GPAP_DIR_RESET = 8'hff;
    localparam logic [7:0] GPAP_CLR = 8'h00;
    localparam logic GPAP_DEBUG_RESET = 1'b1;
    localparam int GPAP_DEBUG_BIT = 0;
    localparam int GPAP_BIT_NMI = 2;
    localparam int GPAP_BIT_IRQ0 = 3;
    localparam int GPAP_BIT_IRQ1 = 4;
    localparam int GPAP_BIT_IRQ2 = 5;
    localparam int GPAP_BIT_IRQ3 = 6;
    localparam int GPAP_BIT_DBGR = 5;
    // {extended select, select} codes for bit 3
    localparam logic [1:0] GPAP_FUNC_IRQ0 = 2'h0;
    localparam logic [1:0] GPAP_FUNC_ADC = 2'h1;
endpackage : gpap_pkg

// ### verilog/gpap_sync.sv
// gpap_sync: two-flop synchroniser for asynchronous pin levels.
// assumes inputs may change at any time relative to clk.
`timescale 1ns/10ps
`default_nettype none
module gpap_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : gpap_sync
`default_nettype wire

// ### verilog/gpap_pad.sv
// gpap_pad: registered drive control of one port pin.
// assumes alternate functions on this port are inputs only.
`timescale 1ns/10ps
`default_nettype none
module gpap_pad (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin configuration
    input wire logic latch,
    input wire logic dir_in,
    input wire logic alt_mode,
    input wire logic open_drain,
    input wire logic force_in,
    // pin drive
    output logic pad_out_q,
    output logic pad_oe_b_q
);
    logic drive_en;

    // only port mode with output direction drives; selects are ignored else
    assign drive_en = !dir_in && !alt_mode && !force_in; // R01 R03 R07 R12

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pad_out_q <= 1'b0;
            pad_oe_b_q <= 1'b1;
        end else if (!drive_en) begin
            pad_out_q <= 1'b0;
            pad_oe_b_q <= 1'b1;
        end else if (open_drain) begin
            // open drain pulls low only; a one releases the pin
            pad_out_q <= 1'b0; // R11
            pad_oe_b_q <= latch; // R11
        end else begin
            pad_out_q <= latch; // R01 R11
            pad_oe_b_q <= 1'b0;
        end
    end
endmodule : gpap_pad
`default_nettype wire

// ### verilog/gpap_top.sv
// gpap_top: port 0 pin block with latch, direction, alternate routing.
// assumes a single-cycle register master on clk and pins sampled async.
`timescale 1ns/10ps
`default_nettype none
module gpap_top
    import gpap_pkg::*;
#(
    parameter int PIN_LO = GPAP_PIN_LO,
    parameter int PIN_N = GPAP_PIN_N
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [GPAP_AW-1:0] addr,
    input wire logic [GPAP_DW-1:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [GPAP_DW-1:0] rdata_q,
    // pins
    input wire logic [PIN_N-1:0] pin_in,
    output logic [PIN_N-1:0] pin_out_q,
    output logic [PIN_N-1:0] pin_oe_b_q,
    // alternate function inputs toward peripherals
    output logic nmi_in_q,
    output logic [3:0] ext_irq_q,
    output logic adc_trigger_q,
    output logic debug_reset_b_q
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    initial begin
        if (PIN_LO + PIN_N > GPAP_DW || PIN_LO < 0 || PIN_N < 1) begin
            $error("pin field does not fit the register width");
        end
        if (PIN_LO > GPAP_BIT_NMI || PIN_LO + PIN_N <= GPAP_BIT_IRQ3) begin
            $error("alternate pins fall outside the pin field");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [GPAP_DW-1:0] data_q;
    logic [GPAP_DW-1:0] dir_q;
    logic [GPAP_DW-1:0] mode_q;
    logic [GPAP_DW-1:0] fsel_q;
    logic [GPAP_DW-1:0] fsele_q;
    logic [GPAP_DW-1:0] drive_q;
    logic debug_en_q;

    logic wr_data;
    logic wr_dir;
    logic wr_mode;
    logic wr_fsel;
    logic wr_fsele;
    logic wr_drive;
    logic wr_debug;

    assign wr_data = we && addr == GPAP_ADDR_DATA;
    assign wr_dir = we && addr == GPAP_ADDR_DIR;
    assign wr_mode = we && addr == GPAP_ADDR_MODE;
    assign wr_fsel = we && addr == GPAP_ADDR_FSEL;
    assign wr_fsele = we && addr == GPAP_ADDR_FSELE;
    assign wr_drive = we && addr == GPAP_ADDR_DRIVE;
    assign wr_debug = we && addr == GPAP_ADDR_DEBUG;

    // the latch is written whatever the direction and mode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_q <= GPAP_CLR;
        end else if (wr_data) begin
            data_q <= wdata & GPAP_PIN_MASK; // R01 R03 R05 R06
        end
    end

    // unused direction bits stay at one so reads show input mode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dir_q <= GPAP_DIR_RESET; // R15
        end else if (wr_dir) begin
            dir_q <= wdata | ~GPAP_PIN_MASK; // R07 R14 R15
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_q <= GPAP_CLR; // R20
        end else if (wr_mode) begin
            mode_q <= wdata & GPAP_PIN_MASK; // R08
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fsel_q <= GPAP_CLR; // R20
        end else if (wr_fsel) begin
            fsel_q <= wdata & GPAP_PIN_MASK; // R09
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fsele_q <= GPAP_CLR; // R20
        end else if (wr_fsele) begin
            fsele_q <= wdata & GPAP_PIN_MASK; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drive_q <= GPAP_CLR; // R20
        end else if (wr_drive) begin
            drive_q <= wdata & GPAP_PIN_MASK; // R11
        end
    end

    // debug enable starts set so bit 5 comes up as the debug reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            debug_en_q <= GPAP_DEBUG_RESET;
        end else if (wr_debug) begin
            debug_en_q <= wdata[GPAP_DEBUG_BIT]; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin sampling

    logic [PIN_N-1:0] pin_sync;
    logic [GPAP_DW-1:0] pin_lvl;

    gpap_sync #(
        .W(PIN_N)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    always_comb begin
        pin_lvl = GPAP_CLR;
        for (int i = 0; i < PIN_N; i++) begin
            pin_lvl[PIN_LO + i] = pin_sync[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive, one registered cell per pin

    for (genvar g = 0; g < PIN_N; g++) begin : g_pad
        logic force_in;
        // debug enable overrides mode control on the shared pin
        assign force_in = (PIN_LO + g == GPAP_BIT_DBGR) && debug_en_q; // R18

        gpap_pad u_pad (
            .clk(clk),
            .rst_b(rst_b),
            .latch(data_q[PIN_LO + g]),
            .dir_in(dir_q[PIN_LO + g]),
            .alt_mode(mode_q[PIN_LO + g]),
            .open_drain(drive_q[PIN_LO + g]),
            .force_in(force_in),
            .pad_out_q(pin_out_q[g]),
            .pad_oe_b_q(pin_oe_b_q[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // alternate function routing

    logic [1:0] func_b3;

    assign func_b3 = {fsele_q[GPAP_BIT_IRQ0], fsel_q[GPAP_BIT_IRQ0]}; // R10

    // unselected alternates sit at their idle level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nmi_in_q <= 1'b0;
            ext_irq_q <= 4'h0;
            adc_trigger_q <= 1'b0;
        end else begin
            nmi_in_q <= mode_q[GPAP_BIT_NMI] && pin_lvl[GPAP_BIT_NMI]; // R16
            ext_irq_q[0] <= mode_q[GPAP_BIT_IRQ0]
                && func_b3 == GPAP_FUNC_IRQ0
                && pin_lvl[GPAP_BIT_IRQ0]; // R09 R19
            adc_trigger_q <= mode_q[GPAP_BIT_IRQ0]
                && func_b3 == GPAP_FUNC_ADC
                && pin_lvl[GPAP_BIT_IRQ0]; // R19
            ext_irq_q[1] <= mode_q[GPAP_BIT_IRQ1] && pin_lvl[GPAP_BIT_IRQ1];
            ext_irq_q[2] <= mode_q[GPAP_BIT_IRQ2] && !debug_en_q
                && pin_lvl[GPAP_BIT_IRQ2]; // R16 R18
            ext_irq_q[3] <= mode_q[GPAP_BIT_IRQ3] && pin_lvl[GPAP_BIT_IRQ3];
        end
    end

    // released (high) whenever debug use of the pin is off
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            debug_reset_b_q <= 1'b1;
        end else begin
            debug_reset_b_q <= debug_en_q ? pin_lvl[GPAP_BIT_DBGR] : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [GPAP_DW-1:0] data_view;
    logic [GPAP_DW-1:0] rd_mux;

    // per bit: latch in output mode, pin level in input mode
    assign data_view = ((data_q & ~dir_q) | (pin_lvl & dir_q))
        & GPAP_PIN_MASK; // R02 R04 R06

    always_comb begin
        rd_mux = GPAP_CLR;
        case (addr)
            GPAP_ADDR_DATA: rd_mux = data_view;
            GPAP_ADDR_DIR: rd_mux = dir_q; // R15
            GPAP_ADDR_MODE: rd_mux = mode_q;
            GPAP_ADDR_FSEL: rd_mux = fsel_q;
            GPAP_ADDR_FSELE: rd_mux = fsele_q;
            GPAP_ADDR_DRIVE: rd_mux = drive_q;
            GPAP_ADDR_DEBUG: rd_mux[GPAP_DEBUG_BIT] = debug_en_q;
            default: rd_mux = GPAP_CLR;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= GPAP_CLR;
        end else if (re) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= GPAP_CLR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    drive_latch_a: assert property ( // R01
        wr_data && !dir_q[GPAP_BIT_NMI] && !mode_q[GPAP_BIT_NMI]
        && !drive_q[GPAP_BIT_NMI] ##1 !we
        |=> pin_out_q[GPAP_BIT_NMI - PIN_LO] == $past(wdata[GPAP_BIT_NMI], 2)
        && !pin_oe_b_q[GPAP_BIT_NMI - PIN_LO])
        else $error("pin does not drive written latch");

    read_latch_a: assert property ( // R02
        re && addr == GPAP_ADDR_DATA && !dir_q[GPAP_BIT_IRQ1]
        |=> rdata_q[GPAP_BIT_IRQ1] == $past(data_q[GPAP_BIT_IRQ1]))
        else $error("output mode read not from latch");

    input_hiz_a: assert property ( // R03
        dir_q[GPAP_BIT_NMI] [*2]
        |-> pin_oe_b_q[GPAP_BIT_NMI - PIN_LO])
        else $error("input pin is driven");

    read_pin_a: assert property ( // R04
        re && addr == GPAP_ADDR_DATA && dir_q[GPAP_BIT_IRQ0]
        |=> rdata_q[GPAP_BIT_IRQ0] == $past(pin_lvl[GPAP_BIT_IRQ0]))
        else $error("input mode read not from pin");

    latch_hold_a: assert property ( // R05
        !wr_data |=> $stable(data_q))
        else $error("latch changed without write");

    open_drain_a: assert property ( // R11
        !dir_q[GPAP_BIT_IRQ3] && !mode_q[GPAP_BIT_IRQ3]
        && drive_q[GPAP_BIT_IRQ3] && data_q[GPAP_BIT_IRQ3]
        |=> pin_oe_b_q[GPAP_BIT_IRQ3 - PIN_LO]
        && !pin_out_q[GPAP_BIT_IRQ3 - PIN_LO])
        else $error("open drain drives a one");

    dir_fixed_a: assert property ( // R15
        re && addr == GPAP_ADDR_DIR
        |=> rdata_q[7] && rdata_q[1] && rdata_q[0])
        else $error("unused direction bits not one");

    debug_pin_a: assert property ( // R18
        debug_en_q
        |=> debug_reset_b_q == $past(pin_lvl[GPAP_BIT_DBGR])
        && !ext_irq_q[2] && pin_oe_b_q[GPAP_BIT_DBGR - PIN_LO])
        else $error("debug reset not routed");

    adc_select_a: assert property ( // R19
        mode_q[GPAP_BIT_IRQ0] && func_b3 == GPAP_FUNC_ADC
        |=> !ext_irq_q[0]
        && adc_trigger_q == $past(pin_lvl[GPAP_BIT_IRQ0]))
        else $error("bit 3 alternate misrouted");

    reset_vals_a: assert property ( // R20
        $past(!rst_b) |-> mode_q == GPAP_CLR && fsel_q == GPAP_CLR
        && drive_q == GPAP_CLR && dir_q == GPAP_DIR_RESET)
        else $error("control reset value wrong");

    output_drive_c: cover property (
        wr_data && !dir_q[GPAP_BIT_NMI] ##2 !pin_oe_b_q[0]);
    adc_trig_c: cover property (adc_trigger_q);
    debug_off_c: cover property (wr_debug && !wdata[GPAP_DEBUG_BIT]);
    open_drain_c: cover property (
        drive_q[GPAP_BIT_IRQ3] && !dir_q[GPAP_BIT_IRQ3]);

endmodule : gpap_top
`default_nettype wire

// ### test/gpap_pins_model.sv
// gpap_pins_model: external devices and pull-ups at the five port 0 pins.
// assumes the bench sets which pins a device drives and at what level.
`timescale 1ns/10ps
`default_nettype none
module gpap_pins_model (
    // block drive
    input wire logic [4:0] pin_out_q,
    input wire logic [4:0] pin_oe_b_q,
    // external devices
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    // resolved wire level
    output logic [4:0] pin_in
);
    ////////////////////////////////////////////////////////////////////
    // block wins while driving; a released pin with no device is pulled
    // high, so a stale level can never pass for a driven one
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!pin_oe_b_q[i]) begin
                pin_in[i] = pin_out_q[i];
            end else begin
                pin_in[i] = ext_en[i] ? ext_val[i] : 1'b1;
            end
        end
    end
endmodule : gpap_pins_model
`default_nettype wire

// ### test/testbench.sv
// testbench: register sequences on the port 0 pin block with checks.
// assumes the pin model in gpap_pins_model and a 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import gpap_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] rdata_q;
    logic [4:0] pin_in, pin_out_q, pin_oe_b_q;
    logic [4:0] ext_en = 5'h1f;
    logic [4:0] ext_val = 5'h05;
    logic nmi_in_q, adc_trigger_q, debug_reset_b_q;
    logic [3:0] ext_irq_q;
    int bad_count = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    gpap_top gpap_top_i (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .we(we), .re(re), .rdata_q(rdata_q),
        .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_b_q(pin_oe_b_q),
        .nmi_in_q(nmi_in_q), .ext_irq_q(ext_irq_q),
        .adc_trigger_q(adc_trigger_q), .debug_reset_b_q(debug_reset_b_q));
    gpap_pins_model gpap_pins_model_i (.pin_out_q(pin_out_q),
        .pin_oe_b_q(pin_oe_b_q), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rdata_q, exp);
    endtask : rd

    // covers the two-flop sync plus output register on alternates
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    function automatic logic [7:0] alt_view;
        return {1'b0, debug_reset_b_q, nmi_in_q, adc_trigger_q, ext_irq_q};
    endfunction : alt_view

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // pin 5 held low by the system until debug is turned off
        ext_val <= 5'h05;
        rd(GPAP_ADDR_DIR, 8'hff);
        rd(GPAP_ADDR_MODE, 8'h00);
        rd(GPAP_ADDR_FSEL, 8'h00);
        rd(GPAP_ADDR_FSELE, 8'h00);
        rd(GPAP_ADDR_DRIVE, 8'h00);
        rd(32'hfffff404, 8'h00);
        chk({3'h0, pin_oe_b_q}, 8'h1f);
        wr(GPAP_ADDR_DATA, 8'h54);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h1f);
        rd(GPAP_ADDR_DATA, 8'h14);
        wr(GPAP_ADDR_DEBUG, 8'h00);
        wr(GPAP_ADDR_DIR, 8'h00);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h00);
        chk({3'h0, pin_out_q}, 8'h15);
        rd(GPAP_ADDR_DATA, 8'h54);
        // mixed directions in one write, each bit set on its own
        wr(GPAP_ADDR_DIR, 8'h28);
        ext_val <= 5'h1f;
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h0a);
        rd(GPAP_ADDR_DIR, 8'hab);
        rd(GPAP_ADDR_DATA, 8'h7c);
        // latch written while input shows once output is selected
        wr(GPAP_ADDR_DIR, 8'hff);
        wr(GPAP_ADDR_DATA, 8'h38);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h1f);
        wr(GPAP_ADDR_DIR, 8'h00);
        settle();
        chk({3'h0, pin_out_q}, 8'h0e);
        wr(GPAP_ADDR_DRIVE, 8'h7c);
        ext_val <= 5'h1d;
        settle();
        chk({3'h0, pin_out_q}, 8'h00);
        chk({3'h0, pin_oe_b_q}, 8'h0e);
        rd(GPAP_ADDR_DATA, 8'h38);
        wr(GPAP_ADDR_DIR, 8'hff);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h1f);
        // selects first, then mode control
        wr(GPAP_ADDR_FSEL, 8'h08);
        wr(GPAP_ADDR_MODE, 8'h7c);
        wr(GPAP_ADDR_DIR, 8'h00);
        ext_val <= 5'h1e;
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h1f);
        chk(alt_view(), 8'h5e);
        rd(GPAP_ADDR_DATA, 8'h38);
        wr(GPAP_ADDR_FSEL, 8'h00);
        settle();
        chk(alt_view(), 8'h4f);
        wr(GPAP_ADDR_FSELE, 8'h08);
        settle();
        chk(alt_view(), 8'h4e);
        wr(GPAP_ADDR_DEBUG, 8'h01);
        ext_val <= 5'h17;
        settle();
        chk(alt_view(), 8'h2a);
        // push-pull again so only the debug override keeps bit 5 released
        wr(GPAP_ADDR_DRIVE, 8'h00);
        wr(GPAP_ADDR_MODE, 8'h00);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h08);
        wr(GPAP_ADDR_DATA, 8'h44);
        settle();
        chk({3'h0, pin_out_q}, 8'h11);
        wr(GPAP_ADDR_DRIVE, 8'h40);
        settle();
        chk({3'h0, pin_oe_b_q}, 8'h18);
        chk({3'h0, pin_out_q}, 8'h01);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
